// [rtl/occ_config.sv]
// register file and output clock steering for the output clock configuration block
`default_nettype none
// Contract
// R1: spread step word feeds the modulator
// R2: ratio zero stops second channel divider
// R3: ratio codes divide by 2..40
// R4: bits 12:5 are numerator high byte
// R5: host writes zeros to bits 4:3
// R6: format 4/5 enable one output only
// R7: format 6 inverts second, 7 in phase
// R8: pin function 0 low, 1 high-impedance
// R9: function 2 reference clock, 3 ready
// R10: pin divisor off, /2, /4, /8
// R11: host writes one to bit 10
// R12: pin clock source select, first default
// R13: host never writes the top bit
// R14: fields load from one-time fuse store
// R15: select bit picks channel source divider
// R16: pair enable bit gates both outputs
// R17: idle state low or high-impedance
// R18: reserved formats leave pair inactive
module occ_config
	import occ_pkg::*;
(
	input wire logic clk_i,                           // 25 MHz
	input wire logic rst_b_i,                         // async, active low
	input wire logic ce_i,                            // freezes all state when low
	input wire occ_wr_t wr_i,                         // host write port
	input wire logic [3:0] rd_addr_i,                 // host read offset
	output logic [15:0] rd_data_o,                    // registered read data
	input wire logic fuse_load_i,                     // one-cycle fuse image load
	input wire occ_fuse_t fuse_i,                     // one_time_fuse_store image
	input wire logic first_frac_tick_i,               // first_frac_divider edge strobe
	input wire logic second_frac_tick_i,              // second_frac_divider edge strobe
	input wire logic second_channel_source_select_i,  // 0 first, 1 second
	input wire logic first_pair_idle_state_i,         // 0 low, 1 high-impedance
	input wire logic clock_ready_i,                   // clock-ready status
	output logic [15:0] spread_step_increment_o,
	output logic [7:0] second_frac_numerator_high_o,
	output logic pair_one_output_one_o,
	output logic pair_one_output_one_oe_o,
	output logic pair_one_output_two_o,
	output logic pair_one_output_two_oe_o,
	output logic mp_pin_o,
	output logic mp_pin_oe_o
);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// half period in source ticks for a channel ratio code
	function automatic logic [4:0] ratio_half(input logic [2:0] code);
		unique case (code)
			3'h1: ratio_half = 5'd1;
			3'h2: ratio_half = 5'd2;
			3'h3: ratio_half = 5'd3;
			3'h4: ratio_half = 5'd4;
			3'h5: ratio_half = 5'd5;
			3'h6: ratio_half = 5'd10;
			3'h7: ratio_half = 5'd20;
			default: ratio_half = 5'd0;
		endcase
	endfunction : ratio_half
	// half period for a pin divisor code
	function automatic logic [4:0] pin_half(input logic [1:0] code);
		unique case (code)
			2'h1: pin_half = 5'd1;
			2'h2: pin_half = 5'd2;
			2'h3: pin_half = 5'd4;
			default: pin_half = 5'd0;
		endcase
	endfunction : pin_half
	// ----------------------------------------------------------------
	// register file
	// ----------------------------------------------------------------
	logic [15:0] spread_reg, spread_next;   // spread_step_increment
	logic [15:0] divfmt_reg, divfmt_next;   // divider_and_pair_format
	logic [15:0] pin_reg, pin_next;         // multipurpose_pin_config
	logic [15:0] rd_reg, rd_next;
	// fuse load wins over a host write in the same cycle
	always_comb begin
		spread_next = spread_reg;
		divfmt_next = divfmt_reg;
		pin_next = pin_reg;
		if (fuse_load_i) begin
			spread_next = fuse_i.spread;                    // R14
			divfmt_next = fuse_i.divfmt;                    // R14
			pin_next = fuse_i.pin & OCC_PIN_WMASK;          // R14
		end else if (wr_i.we) begin
			unique case (wr_i.addr)
				OCC_SPREAD_OFS: spread_next = wr_i.data;
				OCC_DIVFMT_OFS: divfmt_next = wr_i.data;   // bits 4:3 kept as written, R5
				OCC_PIN_OFS: pin_next = wr_i.data & OCC_PIN_WMASK;  // R13 R11
				default: ;                                 // unmapped: ignored
			endcase
		end
		// read mux, unmapped offsets read zero
		unique case (rd_addr_i)
			OCC_SPREAD_OFS: rd_next = spread_reg;
			OCC_DIVFMT_OFS: rd_next = divfmt_reg;
			OCC_PIN_OFS: rd_next = pin_reg;
			default: rd_next = 16'h0000;
		endcase
	end
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			spread_reg <= OCC_SPREAD_RST;
			divfmt_reg <= OCC_DIVFMT_RST;
			pin_reg <= OCC_PIN_RST;
			rd_reg <= 16'h0000;
		end else if (ce_i) begin
			spread_reg <= spread_next;
			divfmt_reg <= divfmt_next;
			pin_reg <= pin_next;
			rd_reg <= rd_next;
		end
	end
	assign rd_data_o = rd_reg;
	assign spread_step_increment_o = spread_reg;                          // R1
	assign second_frac_numerator_high_o = divfmt_reg[OCC_NUMH_HI:OCC_NUMH_LO]; // R4
	// ----------------------------------------------------------------
	// field decode
	// ----------------------------------------------------------------
	logic [2:0] ratio;
	logic [2:0] fmt;
	logic [1:0] func;
	logic [1:0] rdiv;
	assign ratio = divfmt_reg[OCC_RATIO_HI:OCC_RATIO_LO];
	assign fmt = divfmt_reg[OCC_FMT_HI:OCC_FMT_LO];
	assign func = pin_reg[OCC_FUNC_HI:OCC_FUNC_LO];
	assign rdiv = pin_reg[OCC_RDIV_HI:OCC_RDIV_LO];
	logic ch_tick, ref_tick;
	// source selects for the channel divider and the pin clock
	assign ch_tick = second_channel_source_select_i ? second_frac_tick_i
		: first_frac_tick_i;                                          // R15
	assign ref_tick = pin_reg[OCC_RSEL_BIT] ? second_frac_tick_i
		: first_frac_tick_i;                                          // R12
	// ----------------------------------------------------------------
	// dividers: toggle every half period of source ticks
	// ----------------------------------------------------------------
	logic [4:0] ch_cnt_reg, ch_cnt_next, ref_cnt_reg, ref_cnt_next;
	logic ch_clk_reg, ch_clk_next, ref_clk_reg, ref_clk_next;
	always_comb begin
		ch_cnt_next = ch_cnt_reg;
		ch_clk_next = ch_clk_reg;
		ref_cnt_next = ref_cnt_reg;
		ref_clk_next = ref_clk_reg;
		// ratio zero parks the divider low, producing no clock
		if (ratio == 3'h0) begin
			ch_cnt_next = OCC_CNT_ZERO;                  // R2
			ch_clk_next = 1'b0;                          // R2
		end else if (ch_tick) begin
			if (ch_cnt_reg + 5'd1 >= ratio_half(ratio)) begin
				ch_cnt_next = OCC_CNT_ZERO;              // R3
				ch_clk_next = !ch_clk_reg;               // R3
			end else begin
				ch_cnt_next = ch_cnt_reg + 5'd1;
			end
		end
		// divisor zero disables the pin clock
		if (rdiv == 2'h0) begin
			ref_cnt_next = OCC_CNT_ZERO;                 // R10
			ref_clk_next = 1'b0;                         // R10
		end else if (ref_tick) begin
			if (ref_cnt_reg + 5'd1 >= pin_half(rdiv)) begin
				ref_cnt_next = OCC_CNT_ZERO;             // R10
				ref_clk_next = !ref_clk_reg;             // R10
			end else begin
				ref_cnt_next = ref_cnt_reg + 5'd1;
			end
		end
	end
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ch_cnt_reg <= OCC_CNT_ZERO;
			ch_clk_reg <= 1'b0;
			ref_cnt_reg <= OCC_CNT_ZERO;
			ref_clk_reg <= 1'b0;
		end else if (ce_i) begin
			ch_cnt_reg <= ch_cnt_next;
			ch_clk_reg <= ch_clk_next;
			ref_cnt_reg <= ref_cnt_next;
			ref_clk_reg <= ref_clk_next;
		end
	end
	// ----------------------------------------------------------------
	// pin drivers, registered so outputs carry no glitches
	// ----------------------------------------------------------------
	logic [5:0] pins_reg, pins_next;  // {o1, oe1, o2, oe2, mp, mp_oe}
	logic pen, idle_o, idle_oe;
	assign pen = pin_reg[OCC_PEN_BIT];
	assign idle_o = 1'b0;
	assign idle_oe = !first_pair_idle_state_i;               // R17
	always_comb begin
		// disabled or reserved format: idle state on both pins
		pins_next[5:2] = {idle_o, idle_oe, idle_o, idle_oe};  // R16 R18
		if (pen) begin
			unique case (fmt)
				OCC_FMT_ONE: pins_next[5:4] = {ch_clk_next, 1'b1};           // R6
				OCC_FMT_TWO: pins_next[3:2] = {ch_clk_next, 1'b1};           // R6
				OCC_FMT_INV: pins_next[5:2] = {ch_clk_next, 1'b1, !ch_clk_next, 1'b1}; // R7
				OCC_FMT_PH: pins_next[5:2] = {ch_clk_next, 1'b1, ch_clk_next, 1'b1};   // R7
				default: ;                                                     // R18
			endcase
		end
		unique case (func)
			OCC_FUNC_LOW: pins_next[1:0] = 2'b01;                  // R8
			OCC_FUNC_HIZ: pins_next[1:0] = 2'b00;                  // R8
			OCC_FUNC_CLK: pins_next[1:0] = {ref_clk_next, 1'b1};   // R9
			OCC_FUNC_RDY: pins_next[1:0] = {clock_ready_i, 1'b1};  // R9
		endcase
	end
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pins_reg <= 6'h00;
		end else if (ce_i) begin
			pins_reg <= pins_next;
		end
	end
	assign {pair_one_output_one_o, pair_one_output_one_oe_o,
		pair_one_output_two_o, pair_one_output_two_oe_o, mp_pin_o, mp_pin_oe_o} = pins_reg;
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	property p_spread;
		@(posedge clk_i) disable iff (!rst_b_i)
		ce_i && !fuse_load_i && wr_i.we && wr_i.addr == OCC_SPREAD_OFS
		|=> spread_step_increment_o == $past(wr_i.data);
	endproperty
	a_spread: assert property (p_spread) else $error("spread step not stored"); // R1
	property p_ratio_off;
		@(posedge clk_i) disable iff (!rst_b_i)
		ce_i && ratio == 3'h0 |=> !ch_clk_reg && ch_cnt_reg == OCC_CNT_ZERO;
	endproperty
	a_ratio_off: assert property (p_ratio_off) else $error("divider runs at ratio zero"); // R2
	property p_ratio_two;
		@(posedge clk_i) disable iff (!rst_b_i)
		ce_i && ratio == 3'h1 && ch_tick && $past(ratio) == 3'h1
		|=> ch_clk_reg != $past(ch_clk_reg);
	endproperty
	a_ratio_two: assert property (p_ratio_two) else $error("divide by two missed a toggle"); // R3
	property p_numh;
		@(posedge clk_i) disable iff (!rst_b_i)
		ce_i && fuse_load_i |=> second_frac_numerator_high_o == $past(fuse_i.divfmt[12:5]);
	endproperty
	a_numh: assert property (p_numh) else $error("numerator byte wrong after fuse load"); // R4 R14
	property p_fmt_one;
		@(posedge clk_i) disable iff (!rst_b_i)
		ce_i && pen && fmt == OCC_FMT_ONE |=> pair_one_output_one_oe_o
			&& pair_one_output_one_o == ch_clk_reg;
	endproperty
	a_fmt_one: assert property (p_fmt_one) else $error("format four not driving output one"); // R6
	property p_fmt_inv;
		@(posedge clk_i) disable iff (!rst_b_i)
		ce_i && pen && fmt == OCC_FMT_INV
		|=> pair_one_output_two_o == !pair_one_output_one_o;
	endproperty
	a_fmt_inv: assert property (p_fmt_inv) else $error("format six not inverted"); // R7
	property p_hiz;
		@(posedge clk_i) disable iff (!rst_b_i)
		ce_i && func == OCC_FUNC_HIZ |=> !mp_pin_oe_o;
	endproperty
	a_hiz: assert property (p_hiz) else $error("pin driven in high-impedance mode"); // R8
	property p_idle;
		@(posedge clk_i) disable iff (!rst_b_i)
		ce_i && (!pen || fmt < OCC_FMT_ONE)
		|=> pair_one_output_one_oe_o == !$past(first_pair_idle_state_i)
			&& !pair_one_output_one_o && !pair_one_output_two_o;
	endproperty
	a_idle: assert property (p_idle) else $error("inactive pair not in idle state"); // R16 R17 R18
	property p_top_bit;
		@(posedge clk_i) disable iff (!rst_b_i)
		##1 !pin_reg[15];
	endproperty
	a_top_bit: assert property (p_top_bit) else $error("reserved top bit stored"); // R13
endmodule : occ_config
`default_nettype wire

// [rtl/occ_pkg.sv]
// package of constants and carriers for the output clock configuration block
`default_nettype none
package occ_pkg;
	// ----------------------------------------------------------------
	// register offsets, widths and reset values
	// ----------------------------------------------------------------
	localparam logic [3:0] OCC_SPREAD_OFS = 4'h5;   // spread_step_increment
	localparam logic [3:0] OCC_DIVFMT_OFS = 4'h6;   // divider_and_pair_format
	localparam logic [3:0] OCC_PIN_OFS = 4'h7;      // multipurpose_pin_config
	localparam logic [15:0] OCC_SPREAD_RST = 16'h0000;
	localparam logic [15:0] OCC_DIVFMT_RST = 16'h0aa7;
	localparam logic [15:0] OCC_PIN_RST = 16'h5d1f;
	localparam logic [15:0] OCC_PIN_WMASK = 16'h7fff; // top bit never stored
	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int OCC_RATIO_HI = 15;
	localparam int OCC_RATIO_LO = 13;
	localparam int OCC_NUMH_HI = 12;
	localparam int OCC_NUMH_LO = 5;
	localparam int OCC_FMT_HI = 2;
	localparam int OCC_FMT_LO = 0;
	localparam int OCC_FUNC_HI = 14;
	localparam int OCC_FUNC_LO = 13;
	localparam int OCC_RDIV_HI = 12;
	localparam int OCC_RDIV_LO = 11;
	localparam int OCC_RSEL_BIT = 9;
	localparam int OCC_PEN_BIT = 1;
	// ----------------------------------------------------------------
	// field codes
	// ----------------------------------------------------------------
	localparam logic [2:0] OCC_FMT_ONE = 3'h4;   // first output only
	localparam logic [2:0] OCC_FMT_TWO = 3'h5;   // second output only
	localparam logic [2:0] OCC_FMT_INV = 3'h6;   // both, second inverted
	localparam logic [2:0] OCC_FMT_PH = 3'h7;    // both in phase
	localparam logic [1:0] OCC_FUNC_LOW = 2'h0;
	localparam logic [1:0] OCC_FUNC_HIZ = 2'h1;
	localparam logic [1:0] OCC_FUNC_CLK = 2'h2;
	localparam logic [1:0] OCC_FUNC_RDY = 2'h3;
	localparam logic [4:0] OCC_CNT_ZERO = 5'h00;
	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic we;           // one-cycle write strobe
		logic [3:0] addr;   // register offset
		logic [15:0] data;  // write data
	} occ_wr_t;
	typedef struct packed {
		logic [15:0] spread;
		logic [15:0] divfmt;
		logic [15:0] pin;
	} occ_fuse_t;
endpackage : occ_pkg
`default_nettype wire

// [tb/occ_clk_load.sv]
// clock load model that counts level changes seen on a driven output pin
`default_nettype none
module occ_clk_load (
	input wire logic clk_i,    // bench clock
	input wire logic rst_b_i,  // async, active low
	input wire logic pin_i,    // observed clock pin
	input wire logic oe_i,     // pin driven when high
	input wire logic clr_i,    // clears the count
	output int edge_cnt_o      // changes seen while driven
);
	timeunit 1ns;
	timeprecision 1ps;
	logic last_reg;  // pin level at previous edge
	// ------------------------------------------------------------
	// edge counter
	// ------------------------------------------------------------
	// a floating pin carries no clock, so changes only count while driven
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			last_reg <= 1'b0;
			edge_cnt_o <= 0;
		end else begin
			last_reg <= pin_i;
			if (clr_i) begin
				edge_cnt_o <= 0;
			end else if (oe_i && (pin_i !== last_reg)) begin
				edge_cnt_o <= edge_cnt_o + 1;
			end
		end
	end
endmodule : occ_clk_load
`default_nettype wire

// [tb/test_occ_config.sv]
// self-checking bench for the output clock configuration block
`default_nettype none
module test_occ_config import occ_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	occ_wr_t wr = '0;
	logic [3:0] rd_addr = 4'h0;
	logic fuse_load = 1'b0;
	occ_fuse_t fuse = '0;
	logic csel = 1'b0;  // channel fed by first fractional divider
	logic idle = 1'b1;  // idle pins float
	logic rdy = 1'b0;
	logic clr = 1'b0;
	logic ce = 1'b1;     // block clock enable, dropped once to prove the freeze
	logic tick2 = 1'b0;  // second divider strobe, high every other cycle
	logic [15:0] rd_data, spread;
	logic [7:0] numh;
	logic o1, oe1, o2, oe2, mp, mpoe;
	int cnt_a, cnt_m, error_cnt = 0, cmp_count = 0;
	always #20 clk = ~clk;  // 25 MHz
	// half-rate strobe so a source select shows up as a different ratio, not just silence
	always @(negedge clk) begin
		tick2 <= !tick2;
	end
	// ------------------------------------------------------------
	// design and clock loads
	// ------------------------------------------------------------
	// first divider ticks every cycle so toggle counts map straight to ratios;
	// the second ticks every other cycle, so each source gives its own count
	occ_config i_occ_config (.clk_i(clk), .rst_b_i(rst_b), .ce_i(ce), .wr_i(wr),
		.rd_addr_i(rd_addr), .rd_data_o(rd_data), .fuse_load_i(fuse_load), .fuse_i(fuse),
		.first_frac_tick_i(1'b1), .second_frac_tick_i(tick2),
		.second_channel_source_select_i(csel), .first_pair_idle_state_i(idle),
		.clock_ready_i(rdy), .spread_step_increment_o(spread),
		.second_frac_numerator_high_o(numh), .pair_one_output_one_o(o1),
		.pair_one_output_one_oe_o(oe1), .pair_one_output_two_o(o2),
		.pair_one_output_two_oe_o(oe2), .mp_pin_o(mp), .mp_pin_oe_o(mpoe));
	occ_clk_load i_load_a (.clk_i(clk), .rst_b_i(rst_b), .pin_i(o1), .oe_i(oe1),
		.clr_i(clr), .edge_cnt_o(cnt_a));
	occ_clk_load i_load_m (.clk_i(clk), .rst_b_i(rst_b), .pin_i(mp), .oe_i(mpoe),
		.clr_i(clr), .edge_cnt_o(cnt_m));
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic end_sim;
		$display("checks %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(negedge clk);
		wr <= '{we: 1'b1, addr: a, data: d};
		@(negedge clk);
		wr.we <= 1'b0;
		repeat (3) @(negedge clk);  // let pins follow the new word
	endtask : wr_reg
	task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
		@(negedge clk);
		rd_addr <= a;
		@(negedge clk);
		chk("read data", exp, rd_data);
	endtask : rd_chk
	// pin word: function, divisor, source, pair enable; bit 10 always one
	function automatic logic [15:0] pin_w(input int f, d, s, en);
		return {1'b0, 2'(f), 2'(d), 1'b1, 1'(s), 7'h47, 1'(en), 1'b1};
	endfunction : pin_w
	task automatic count(input int n);
		@(negedge clk);
		clr <= 1'b1;
		@(negedge clk);
		clr <= 1'b0;
		repeat (n) @(negedge clk);
	endtask : count
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_regs;
		rd_chk(OCC_SPREAD_OFS, 16'h0000);
		rd_chk(OCC_DIVFMT_OFS, 16'h0aa7);
		rd_chk(OCC_PIN_OFS, 16'h5d1f);
		rd_chk(4'h3, 16'h0000);
		wr_reg(OCC_SPREAD_OFS, 16'hbeef);
		chk("spread step", 16'hbeef, spread);
		wr_reg(OCC_DIVFMT_OFS, {3'h0, 8'ha5, 2'b00, OCC_FMT_PH});
		chk("numerator high", 16'h00a5, {8'h00, numh});
		wr_reg(OCC_PIN_OFS, 16'hdd1f);  // top bit written on purpose
		rd_chk(OCC_PIN_OFS, 16'h5d1f);
	endtask : t_regs
	// each divider code must give its ratio over a window all ratios divide
	task automatic t_ratio;
		int half[8] = '{0, 1, 2, 3, 4, 5, 10, 20};
		for (int k = 0; k < 8; k++) begin
			wr_reg(OCC_DIVFMT_OFS, {3'(k), 8'h55, 2'b00, OCC_FMT_PH});
			count(120);
			chk("channel toggles", 16'((k == 0) ? 0 : 120 / half[k]), 16'(cnt_a));
		end
		csel = 1'b1;  // half-rate second divider: code 7 toggles every 40 cycles
		count(120);
		chk("source select", 16'h0003, 16'(cnt_a));
		csel = 1'b0;
	endtask : t_ratio
	task automatic t_format;
		for (int f = 0; f < 8; f++) begin
			wr_reg(OCC_DIVFMT_OFS, {3'h1, 8'h55, 2'b00, 3'(f)});
			chk("first oe", 16'(f == 4 || f >= 6), 16'(oe1));
			chk("second oe", 16'(f >= 5), 16'(oe2));
			if (f == 6) chk("inverted pair", 16'(!o1), 16'(o2));
			if (f == 7) chk("in phase pair", 16'(o1), 16'(o2));
		end
		wr_reg(OCC_PIN_OFS, pin_w(2, 3, 0, 0));
		chk("idle float oe", 16'h0000, 16'(oe1));
		idle = 1'b0;
		@(negedge clk);
		@(negedge clk);
		chk("idle low", 16'h0002, {14'h0, oe1, o1});
		idle = 1'b1;
	endtask : t_format
	task automatic t_pin;
		int half[4] = '{0, 1, 2, 4};
		for (int d = 0; d < 4; d++) begin
			wr_reg(OCC_PIN_OFS, pin_w(2, d, 0, 1));
			count(120);
			chk("pin toggles", 16'((d == 0) ? 0 : 120 / half[d]), 16'(cnt_m));
		end
		wr_reg(OCC_PIN_OFS, pin_w(2, 1, 1, 1));
		count(120);
		chk("pin source", 16'h003c, 16'(cnt_m));
		wr_reg(OCC_PIN_OFS, pin_w(0, 3, 0, 1));
		chk("pin low", 16'h0002, {14'h0, mpoe, mp});
		wr_reg(OCC_PIN_OFS, pin_w(1, 3, 0, 1));
		chk("pin float", 16'h0000, 16'(mpoe));
		wr_reg(OCC_PIN_OFS, pin_w(3, 3, 0, 1));
		for (int r = 1; r >= 0; r--) begin
			rdy = 1'(r);
			repeat (3) @(negedge clk);
			chk("ready pin", {14'h0, 1'b1, 1'(r)}, {14'h0, mpoe, mp});
		end
	endtask : t_pin
	task automatic t_fuse;
		fuse = '{spread: 16'h1234, divfmt: 16'h6a46, pin: 16'h3c1d};
		@(negedge clk);
		fuse_load <= 1'b1;
		@(negedge clk);
		fuse_load <= 1'b0;
		rd_chk(OCC_SPREAD_OFS, 16'h1234);
		rd_chk(OCC_DIVFMT_OFS, 16'h6a46);
		rd_chk(OCC_PIN_OFS, 16'h3c1d);
		// a frozen block must not take a host write
		ce = 1'b0;
		wr_reg(OCC_SPREAD_OFS, 16'h0f0f);
		ce = 1'b1;
		rd_chk(OCC_SPREAD_OFS, 16'h1234);
	endtask : t_fuse
	// ------------------------------------------------------------
	// main sequence and hang guard
	// ------------------------------------------------------------
	initial begin
		repeat (8) @(negedge clk);
		rst_b = 1'b1;
		t_regs();
		t_ratio();
		t_format();
		t_pin();
		t_fuse();
		end_sim();
	end
	initial begin
		#2ms;
		error_cnt++;
		end_sim();
	end
endmodule : test_occ_config
`default_nettype wire
